// >>> osc_pkg.sv
// shared constants and types for the octal switch output control
package osc_pkg;

  localparam int          CH_N          = 8;
  localparam int          DIRECT_N      = 3;
  localparam int          DIRECT_LO     = 5;
  localparam int          WORD_W        = 16;
  localparam int          CNT_W         = 4;

  // command word field positions
  localparam int          KEY_HI        = 15;
  localparam int          KEY_LO        = 12;
  localparam int          SEL_HI        = 11;
  localparam int          SEL_LO        = 8;
  localparam int          DATA_HI       = 7;
  localparam int          DATA_LO       = 0;

  // command word codes
  localparam logic [3:0]  KEY_CODE      = 4'ha;
  localparam logic [3:0]  SEL_OUTPUT    = 4'hc;
  localparam logic [3:0]  SEL_DIAG      = 4'h3;
  localparam logic [3:0]  SEL_PROTECT   = 4'ha;
  localparam logic [3:0]  LAST_BIT      = 4'hf;

  // reset values: all off, unlatched, switch-off protection
  localparam logic [7:0]  CMD_ON_RST    = 8'h00;
  localparam logic [7:0]  LATCH_RST     = 8'h00;
  localparam logic [7:0]  LIMIT_RST     = 8'h00;
  localparam logic [15:0] WORD_RST      = 16'h0000;

  // fault filter interval
  localparam int          CLK_PERIOD_NS = 8;
  localparam int          FILT_MIN_NS   = 5000;
  localparam int          FILT_MAX_NS   = 20000;
  localparam int          FILT_CYCLES   = (FILT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          FILT_MAX_CYC  = FILT_MAX_NS / CLK_PERIOD_NS;
  localparam int          FILT_W        = 12;

  typedef struct packed {
    logic [3:0] key;
    logic [3:0] sel;
    logic [7:0] data;
  } osc_cmd_word_t;

  typedef struct packed {
    logic [WORD_W-1:0] shift;
    logic              frame_ok;
    logic              word_seq;
  } osc_link_state_t;

  typedef struct packed {
    logic                       cs_s1;
    logic                       cs_s2;
    logic                       cs_s3;
    logic                       seq_s1;
    logic                       seq_s2;
    logic                       seq_seen;
    logic [DIRECT_N-1:0]        en_s1;
    logic [DIRECT_N-1:0]        en_s2;
    logic [CH_N-1:0]            oc_s1;
    logic [CH_N-1:0]            oc_s2;
    logic [CH_N-1:0]            od_s1;
    logic [CH_N-1:0]            od_s2;
    logic [CH_N-1:0]            hs_s1;
    logic [CH_N-1:0]            hs_s2;
    logic [CH_N-1:0]            cmd_on;
    logic [CH_N-1:0]            latch;
    logic [CH_N-1:0]            limit;
    logic [CH_N-1:0]            trip;
    logic [CH_N-1:0][FILT_W-1:0] filt_cnt;
    logic [CH_N-1:0]            fault;
    logic [CH_N-1:0]            out;
    logic [CH_N-1:0]            ilim_en;
    logic [CH_N-1:0]            diag_gnd_en;
    logic [CH_N-1:0]            diag_bat_en;
    logic                       accept;
    logic                       reject;
  } osc_ctrl_state_t;

endpackage

// >>> osc_link_rx.sv
// serial link receiver running on the link clock
`timescale 1ns/100ps
module osc_link_rx
  import osc_pkg::*;
(
  input  wire logic          sclk,
  input  wire logic          rst_n,
  input  wire logic          cs_n,
  input  wire logic          di,
  output osc_cmd_word_t      word,
  output logic               frame_ok,
  output logic               word_seq
);

  osc_link_state_t   s_reg;
  osc_link_state_t   s_next;
  logic [CNT_W-1:0]  cnt_reg;
  logic              done_reg;

  // bit counter restarts with every frame; sclk may stand still between frames
  always_ff @(posedge sclk or negedge rst_n or posedge cs_n) begin
    if (!rst_n) begin
      cnt_reg  <= 4'h0;
      done_reg <= 1'b0;
    end else if (cs_n) begin
      cnt_reg  <= 4'h0;
      done_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
      if (cnt_reg == LAST_BIT) begin
        done_reg <= 1'b1;
      end
    end
  end

  always_comb begin
    s_next = s_reg;
    // lsb arrives first, so shift in from the top
    s_next.shift = {di, s_reg.shift[WORD_W-1:1]};
    s_next.frame_ok = (cnt_reg == LAST_BIT);
    // one toggle per frame, else a two-word daisy frame cancels itself
    if (cnt_reg == LAST_BIT && !done_reg) begin
      s_next.word_seq = ~s_reg.word_seq;
    end
  end

  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // daisy chain: the last 16 bits of a frame belong to this device
  assign word     = osc_cmd_word_t'(s_reg.shift);
  assign frame_ok = s_reg.frame_ok;
  assign word_seq = s_reg.word_seq;

endmodule // osc_link_rx

// >>> osc_output_ctrl.sv
// output, protection and diagnostic control for eight load switches
//
// Operation
// - serial command bit switches each output
// - per output: switch-off or linear limitation
// - switch-off protection is the power-up default
// - outputs 6-8: serial bit OR enable pin
// - enable pin high forces output on
// - enable pin low leaves serial command control
// - open enable pin reads low
// - reset low clears state, outputs off
// - open reset pin reads high
// - fault persists 5 to 20 us before flag
// - low-side off-state diagnostics only when off
// - high-side off-state diagnostics only when off
// - key 1010 in top nibble required
// - select nibble: output, diag or protection
// - low byte: per-output on, latch or limit bit
// - reset gives off, unlatched, switch-off protection
`timescale 1ns/100ps
module osc_output_ctrl
  import osc_pkg::*;
#(
  parameter int FILT_CYCLES_P = FILT_CYCLES
)
(
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                sclk,
  input  wire logic                cs_n,
  input  wire logic                di,
  input  wire logic                direct_enable_ch6,
  input  wire logic                direct_enable_ch7,
  input  wire logic                direct_enable_ch8,
  input  wire logic [CH_N-1:0]     overcurrent_sense,
  input  wire logic [CH_N-1:0]     offload_sense,
  input  wire logic [CH_N-1:0]     high_side_cfg,
  output logic      [CH_N-1:0]     load_switch_outputs,
  output logic      [CH_N-1:0]     current_limit_en,
  output logic      [CH_N-1:0]     diag_gnd_en,
  output logic      [CH_N-1:0]     diag_bat_en,
  output logic      [CH_N-1:0]     fault_flags,
  output logic      [CH_N-1:0]     latch_mode,
  output logic      [CH_N-1:0]     limit_mode,
  output logic                     cmd_accept,
  output logic                     cmd_reject
);

  // the filter must fit its counter and stay at or below the 20 us maximum
  if (FILT_CYCLES_P < 1 || FILT_CYCLES_P > FILT_MAX_CYC ||
      FILT_CYCLES_P >= (1 << FILT_W)) begin : g_bad_filt
    $error("osc_output_ctrl: FILT_CYCLES_P out of range");
  end

  localparam logic [FILT_W-1:0] FILT_LAST = FILT_W'(FILT_CYCLES_P - 1);

  // reset release synchroniser
  logic rst_s1_reg;
  logic rst_s2_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end

  // pad pull-up keeps rst_n high when open

  osc_cmd_word_t link_word;
  logic          link_frame_ok;
  logic          link_seq;

  osc_link_rx u_link_rx (
    .sclk     (sclk),
    .rst_n    (rst_s2_reg),
    .cs_n     (cs_n),
    .di       (di),
    .word     (link_word),
    .frame_ok (link_frame_ok),
    .word_seq (link_seq)
  );

  osc_ctrl_state_t s_reg;
  osc_ctrl_state_t s_next;

  function automatic logic [FILT_W-1:0] filt_step(
    input logic              cond,
    input logic [FILT_W-1:0] cnt
  );
    // saturate at the last count; any gap in the fault restarts the filter
    if (!cond) begin
      filt_step = '0;
    end else if (cnt == FILT_LAST) begin
      filt_step = cnt;
    end else begin
      filt_step = cnt + FILT_W'(1);
    end
  endfunction

  logic            cs_rise;
  logic            fresh;
  logic            key_ok;
  logic            accept;
  logic            accept_out;
  logic [CH_N-1:0] on_req;
  logic [CH_N-1:0] on_eff;
  logic [CH_N-1:0] cond;
  logic [CH_N-1:0] filt_hit;
  logic [CH_N-1:0] oc_hit;

  always_comb begin
    s_next = s_reg;

    // two flops on every pin before use
    s_next.cs_s1  = cs_n;
    s_next.cs_s2  = s_reg.cs_s1;
    s_next.cs_s3  = s_reg.cs_s2;
    s_next.seq_s1 = link_seq;
    s_next.seq_s2 = s_reg.seq_s1;
    s_next.en_s1  = {direct_enable_ch8, direct_enable_ch7, direct_enable_ch6};
    s_next.en_s2  = s_reg.en_s1;
    s_next.oc_s1  = overcurrent_sense;
    s_next.oc_s2  = s_reg.oc_s1;
    s_next.od_s1  = offload_sense;
    s_next.od_s2  = s_reg.od_s1;
    s_next.hs_s1  = high_side_cfg;
    s_next.hs_s2  = s_reg.hs_s1;

    // the link word is still once chip select is high, so a synced edge may read it
    cs_rise = s_reg.cs_s2 & ~s_reg.cs_s3;
    // a frame without a completed word leaves the sequence toggle alone
    fresh   = s_reg.seq_s2 != s_reg.seq_seen;
    key_ok  = link_word.key == KEY_CODE;
    accept  = cs_rise & fresh & link_frame_ok & key_ok;
    accept_out = 1'b0;
    if (cs_rise) begin
      s_next.seq_seen = s_reg.seq_s2;
    end

    if (accept) begin
      case (link_word.sel)
        SEL_OUTPUT: begin
          s_next.cmd_on = link_word.data;
          accept_out    = 1'b1;
        end
        SEL_DIAG: begin
          s_next.latch = link_word.data;
        end
        SEL_PROTECT: begin
          s_next.limit = link_word.data;
        end
        default: begin
          s_next.cmd_on = s_reg.cmd_on;
        end
      endcase
    end
    s_next.accept = accept;
    s_next.reject = cs_rise & ~accept;

    // open pin pulled low, serial alone rules
    on_req = s_reg.cmd_on | {s_reg.en_s2, {DIRECT_LO{1'b0}}};
    on_eff = on_req & ~s_reg.trip;

    for (int i = 0; i < CH_N; i++) begin
      // overcurrent counts while on, load diagnostics while off
      cond[i] = on_eff[i] ? s_reg.oc_s2[i] : s_reg.od_s2[i];
      // fault must persist through the filter
      s_next.filt_cnt[i] = filt_step(cond[i], s_reg.filt_cnt[i]);
      filt_hit[i] = cond[i] & (s_reg.filt_cnt[i] == FILT_LAST);
      oc_hit[i]   = filt_hit[i] & on_eff[i] & ~s_reg.limit[i];

      // latched flags wait for a valid word; set wins over the clear
      if (filt_hit[i]) begin
        s_next.fault[i] = 1'b1;
      end else if (s_reg.latch[i] ? accept : ~cond[i]) begin
        s_next.fault[i] = 1'b0;
      end

      if (oc_hit[i]) begin
        s_next.trip[i] = 1'b1;
      end else if (accept_out) begin
        s_next.trip[i] = 1'b0;
      end
    end

    s_next.out     = on_eff & ~oc_hit;
    s_next.ilim_en = s_reg.limit & on_eff;
    s_next.diag_gnd_en = ~on_eff & ~s_reg.hs_s2;
    s_next.diag_bat_en = ~on_eff & s_reg.hs_s2;
  end

  always_ff @(posedge clk or negedge rst_s2_reg) begin
    if (!rst_s2_reg) begin
      s_reg        <= '0;
      s_reg.cs_s1  <= 1'b1;
      s_reg.cs_s2  <= 1'b1;
      s_reg.cs_s3  <= 1'b1;
      s_reg.cmd_on <= CMD_ON_RST;
      s_reg.latch  <= LATCH_RST;
      s_reg.limit  <= LIMIT_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign load_switch_outputs = s_reg.out;
  assign current_limit_en    = s_reg.ilim_en;
  assign diag_gnd_en         = s_reg.diag_gnd_en;
  assign diag_bat_en         = s_reg.diag_bat_en;
  assign fault_flags         = s_reg.fault;
  assign latch_mode          = s_reg.latch;
  assign limit_mode          = s_reg.limit;
  assign cmd_accept          = s_reg.accept;
  assign cmd_reject          = s_reg.reject;

endmodule // osc_output_ctrl

// >>> osc_checker.sv
// assertion checker for the octal switch output control
`timescale 1ns/100ps
module osc_checker
  import osc_pkg::*;
#(
  parameter int FILT_CYCLES_P = FILT_CYCLES
)
(
  input wire logic            clk,
  input wire logic            rst_n,
  input wire logic            direct_enable_ch8,
  input wire logic [CH_N-1:0] overcurrent_sense,
  input wire logic [CH_N-1:0] offload_sense,
  input wire logic [CH_N-1:0] load_switch_outputs,
  input wire logic [CH_N-1:0] current_limit_en,
  input wire logic [CH_N-1:0] diag_gnd_en,
  input wire logic [CH_N-1:0] diag_bat_en,
  input wire logic [CH_N-1:0] fault_flags,
  input wire logic [CH_N-1:0] latch_mode,
  input wire logic [CH_N-1:0] limit_mode,
  input wire logic            cmd_accept,
  input wire logic            cmd_reject
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_pulse; cmd_accept |=> !cmd_accept && !cmd_reject; endproperty
  a_pulse: assert property (p_pulse) else $error("accept pulse too long");
  // one cycle of lag allowed while an output turns on
  property p_diag; ((diag_gnd_en | diag_bat_en) & load_switch_outputs
    & $past(load_switch_outputs)) == 8'h00; endproperty
  a_diag: assert property (p_diag) else $error("diagnostics while on");
  property p_direct; direct_enable_ch8 [*5] |-> load_switch_outputs[7]; endproperty
  a_direct: assert property (p_direct) else $error("enable pin ignored");
  property p_filter; $rose(fault_flags[0]) |->
    $past(overcurrent_sense[0] | offload_sense[0], FILT_CYCLES_P); endproperty
  a_filter: assert property (p_filter) else $error("fault flag too early");
  property p_reject; cmd_reject |-> limit_mode == $past(limit_mode, 3)
    && latch_mode == $past(latch_mode, 3); endproperty
  a_reject: assert property (p_reject) else $error("rejected word applied");
  property p_cause; $changed(limit_mode) || $changed(latch_mode) |->
    ##[0:2] cmd_accept; endproperty
  a_cause: assert property (p_cause) else $error("mode changed alone");
  property p_dflt; $rose(rst_n) |-> limit_mode == 8'h00 && latch_mode == 8'h00
    && load_switch_outputs == 8'h00; endproperty
  a_dflt: assert property (p_dflt) else $error("reset defaults wrong");
  property p_limit;
    (current_limit_en & ~limit_mode & ~$past(limit_mode)) == 8'h00; endproperty
  a_limit: assert property (p_limit) else $error("limit without mode");
endmodule // osc_checker

bind osc_output_ctrl osc_checker #(.FILT_CYCLES_P(FILT_CYCLES_P)) osc_checker_i (
  .clk, .rst_n, .direct_enable_ch8, .overcurrent_sense, .offload_sense,
  .load_switch_outputs, .current_limit_en, .diag_gnd_en, .diag_bat_en,
  .fault_flags, .latch_mode, .limit_mode, .cmd_accept, .cmd_reject);

// >>> osc_host_model.sv
// host model driving the serial command link
`timescale 1ns/100ps
module osc_host_model (
  output logic sclk,
  output logic cs_n,
  output logic di
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    di   = 1'b0;
  end
  // key and select sent lsb first
  task automatic send(input logic [31:0] w, input int n);
    // odd delay keeps cs_n edges off the clk edges
    #62;
    cs_n = 1'b0;
    #455;
    for (int i = 0; i < n; i++) begin
      di = w[i];
      #15;
      sclk = 1'b1;
      #15;
      sclk = 1'b0;
    end
    // released line shows the inverse, not the last bit
    di = ~di;
    #50;
    cs_n = 1'b1;
  endtask
endmodule // osc_host_model

// >>> tb_top.sv
// testbench for the octal switch output control
`timescale 1ns/100ps
module tb_top;
  import osc_pkg::*;
  logic            clk               = 1'b0;
  logic            rst_n             = 1'b0;
  logic            direct_enable_ch6 = 1'b0;
  logic            direct_enable_ch7 = 1'b0;
  logic            direct_enable_ch8 = 1'b0;
  logic [CH_N-1:0] overcurrent_sense = 8'h00;
  logic [CH_N-1:0] offload_sense     = 8'h00;
  logic [CH_N-1:0] high_side_cfg     = 8'h0f;
  logic            sclk, cs_n, di, cmd_accept, cmd_reject;
  logic [CH_N-1:0] load_switch_outputs, current_limit_en, diag_gnd_en;
  logic [CH_N-1:0] diag_bat_en, fault_flags, latch_mode, limit_mode;
  int              fails             = 0;
  int              n_checks          = 0;

  always #4 clk = ~clk;

  // short filter keeps the fault run brief
  osc_output_ctrl #(.FILT_CYCLES_P(4)) osc_output_ctrl_i (.clk, .rst_n, .sclk, .cs_n,
    .di, .direct_enable_ch6, .direct_enable_ch7, .direct_enable_ch8,
    .overcurrent_sense, .offload_sense, .high_side_cfg, .load_switch_outputs,
    .current_limit_en, .diag_gnd_en, .diag_bat_en, .fault_flags, .latch_mode,
    .limit_mode, .cmd_accept, .cmd_reject);
  osc_host_model osc_host_model_i (.sclk, .cs_n, .di);

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask

  // sends a frame, then waits a bounded time for the verdict pulse
  task automatic cmd(input logic [31:0] w, input int n, input logic acc);
    logic a, r;
    a = 1'b0;
    r = 1'b0;
    @(negedge clk);
    osc_host_model_i.send(w, n);
    for (int i = 0; i < 30 && !(a | r); i++) begin
      @(negedge clk);
      a = (cmd_accept === 1'b1);
      r = (cmd_reject === 1'b1);
    end
    if (!(a | r)) begin
      fails++;
      end_of_test();
    end else begin
      chk("accept", {7'h00, a}, {7'h00, acc});
      chk("reject", {7'h00, r}, {7'h00, ~acc});
      idle(2);
    end
  endtask

  task automatic t_words;
    cmd(32'hac5a_1234, 32, 1'b1);
    chk("outputs", load_switch_outputs, 8'h5a);
    chk("gnd diag", diag_gnd_en, 8'ha0);
    chk("bat diag", diag_bat_en, 8'h05);
    cmd(32'ha3f0, 16, 1'b1);
    chk("latch", latch_mode, 8'hf0);
    cmd(32'haa0f, 16, 1'b1);
    chk("limit", limit_mode, 8'h0f);
    chk("limit en", current_limit_en, 8'h0a);
    cmd(32'ha5ff, 16, 1'b1);
    chk("latch kept", latch_mode, 8'hf0);
    cmd(32'h5cff, 16, 1'b0);
    cmd(32'h00ac_ff00, 24, 1'b0);
    cmd(32'h0, 0, 1'b0);
    chk("outputs kept", load_switch_outputs, 8'h5a);
  endtask

  task automatic t_direct;
    cmd(32'hac00, 16, 1'b1);
    {direct_enable_ch8, direct_enable_ch7, direct_enable_ch6} = 3'h5;
    idle(8);
    chk("forced on", load_switch_outputs, 8'ha0);
    cmd(32'hac20, 16, 1'b1);
    {direct_enable_ch8, direct_enable_ch7, direct_enable_ch6} = 3'h0;
    idle(8);
    chk("pin low", load_switch_outputs, 8'h20);
  endtask

  // output 1 latched, so its flag outlives the trip that removes its cause
  task automatic t_fault;
    cmd(32'haa00, 16, 1'b1);
    cmd(32'ha3f1, 16, 1'b1);
    cmd(32'hac01, 16, 1'b1);
    overcurrent_sense = 8'h01;
    offload_sense = 8'h02;
    idle(2);
    chk("early flag", fault_flags, 8'h00);
    idle(14);
    chk("flags", fault_flags, 8'h03);
    chk("tripped", load_switch_outputs, 8'h00);
    overcurrent_sense = 8'h00;
    offload_sense = 8'h00;
    idle(10);
    chk("unlatched", fault_flags, 8'h01);
    cmd(32'hac00, 16, 1'b1);
    chk("latch cleared", fault_flags, 8'h00);
  endtask

  task automatic t_reset;
    cmd(32'hacff, 16, 1'b1);
    rst_n = 1'b0;
    idle(1);
    chk("reset outs", load_switch_outputs, 8'h00);
    chk("reset limit", limit_mode, 8'h00);
    rst_n = 1'b1;
    idle(6);
    chk("restart", load_switch_outputs, 8'h00);
  endtask

  initial begin
    idle(3);
    chk("power on", load_switch_outputs | latch_mode, 8'h00);
    chk("default prot", limit_mode, 8'h00);
    rst_n = 1'b1;
    idle(6);
    t_words();
    t_direct();
    t_fault();
    t_reset();
    end_of_test();
  end
endmodule // tb_top
